// File: logic/settle_pkg.sv
/*
 holds the shared constants and types of the measurement settling averager.
 assumes a single 10 MHz core clock and a synchronous active-high reset.
*/
package settle_pkg;
   localparam int SAMPLE_W = 16; // width of one converter reading
   localparam int BLOCK_PAIRS = 16; // pairs per short block average
   localparam int MID_SAMPLES = 64; // stable samples before the mid average
   localparam int LONG_SAMPLES = 128; // stable samples before the long average
   localparam logic [SAMPLE_W-1:0] CHANGE_LSB = 16'h0006; // change threshold
   localparam int STATUS_SETTLING_BIT = 1; // settling flag position in status word
   localparam logic [15:0] STATUS_RESET = 16'h0000; // status word reset value
   localparam int CLK_HZ = 10000000; // core clock rate
   localparam int SETPOINT_RATE_MS = 25; // free running setpoint rate
   localparam int SYNC_BOUND_MS = 55; // synchronous response bound
   localparam int TWO_STRING_MS = 63; // two-string response bound
   localparam int SPLIT_MS = 100; // split-command response bound
   localparam int WAIT_EXTRA_MS = 30; // added delay per separate wait
   localparam int SYNC_BOUND_CYC = SYNC_BOUND_MS * (CLK_HZ / 1000); // bound in cycles
   localparam int SUM_W = SAMPLE_W + 8; // accumulator width for 128 samples
   // report kinds
   typedef enum logic [1:0] {
      REP_BLOCK = 2'h0,
      REP_MID = 2'h1,
      REP_LONG = 2'h3
   } report_kind_t;
endpackage

// File: logic/pair_sampler.sv
/*
 captures one voltage and one current reading as a pair on the same strobe.
 assumes the converter strobe comes from logic on core_clk.
*/
module pair_sampler (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic conv_strobe,
   input wire logic [settle_pkg::SAMPLE_W-1:0] volt_in,
   input wire logic [settle_pkg::SAMPLE_W-1:0] curr_in,
   output logic pair_valid,
   output logic [settle_pkg::SAMPLE_W-1:0] volt_out,
   output logic [settle_pkg::SAMPLE_W-1:0] curr_out
);
   typedef struct packed {
      logic vld;
      logic [settle_pkg::SAMPLE_W-1:0] v;
      logic [settle_pkg::SAMPLE_W-1:0] c;
   } samp_t;
   samp_t s_r, s_nxt;

   ////////////////////////////////////////////////////////////////////
   // both readings latched together so a pair never mixes cycles
   always_comb begin
      s_nxt = s_r;
      s_nxt.vld = conv_strobe;
      if (conv_strobe) begin
         s_nxt.v = volt_in; // RL19
         s_nxt.c = curr_in; // RL19
      end
      if (reset) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      s_r <= s_nxt;
   end

   assign pair_valid = s_r.vld;
   assign volt_out = s_r.v;
   assign curr_out = s_r.c;
endmodule

// File: logic/report_buffer.sv
/*
 two-entry buffer between the averager and the consumers; the head entry
 drives the outputs straight from its flops.
 assumes the consumer may hold out_ready low for any time.
*/
module report_buffer (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [2*settle_pkg::SAMPLE_W+1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [2*settle_pkg::SAMPLE_W+1:0] out_data
);
   typedef struct packed {
      logic hv; // head entry holds a word
      logic [2*settle_pkg::SAMPLE_W+1:0] hd; // head word, shown to the consumer
      logic tv; // tail entry holds a word
      logic [2*settle_pkg::SAMPLE_W+1:0] td; // tail word, waits behind the head
   } buf_t;
   buf_t b_r, b_nxt;

   ////////////////////////////////////////////////////////////////////
   // head and tail entries; ready drops only when both are taken
   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      b_nxt = b_r;
      push = in_valid && !b_r.tv;
      pop = out_ready && b_r.hv;
      if (b_r.hv && !pop) begin
         // head stalled: a new word waits in the tail
         if (push) begin
            b_nxt.tv = 1'b1;
            b_nxt.td = in_data;
         end
      end else if (b_r.tv) begin
         // head free: the older tail word moves up first to keep order
         b_nxt.hd = b_r.td;
         b_nxt.hv = 1'b1;
         b_nxt.tv = 1'b0;
      end else begin
         // empty or draining: a new word goes straight to the head
         b_nxt.hv = push;
         if (push) begin
            b_nxt.hd = in_data;
         end
      end
      if (reset) begin
         b_nxt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      b_r <= b_nxt;
   end

   assign in_ready = !b_r.tv;
   assign out_valid = b_r.hv;
   assign out_data = b_r.hd;
endmodule

// File: logic/measurement_settling_averager.sv
/*
 top of the measurement settling averager: pairs, block averages, change
 detection, 64 and 128 sample averages, settling status and sync restart.
 assumes conversions, setpoint strobes and wait requests come from logic on
 core_clk, and that the consumer drains reports through valid and ready.
*/
// Notes on behaviour
// (RL1) average each 16 pairs, compare with last report
// (RL2) on change report this and next block
// (RL3) free running threshold is six LSBs
// (RL4) stable for 64 samples: report 64 average
// (RL5) stable for 128 samples: report 128 average
// (RL6) settling shown as status bit one
// (RL7) sync mode: setpoint change restarts block
// (RL8) first block after restart always reported
// (RL9) after forced report, continue to long averages
// (RL10) power-up selects free running measuring
// (RL11) free running reports uncorrelated with setpoints
// (RL12) sync bipolar: valid reading within 55 ms
// (RL13) power-up selects legacy command set
// (RL14) wait holds until setpoint data valid
// (RL15) combined query returns volt, current, status
// (RL16) two strings answer within 63 ms
// (RL17) split commands within 100 ms, wait adds 30
// (RL18) host picks bipolar, sync, then waits
// (RL19) pair is one volt, one current conversion
module measurement_settling_averager (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic conv_strobe,
   input wire logic [settle_pkg::SAMPLE_W-1:0] volt_in,
   input wire logic [settle_pkg::SAMPLE_W-1:0] curr_in,
   input wire logic measurement_timing_select_wr,
   input wire logic measurement_timing_select_sync,
   input wire logic legacy_command_set_wr,
   input wire logic legacy_command_set_val,
   input wire logic setpoint_change,
   input wire logic wait_request,
   input wire logic combined_readback_query,
   output logic rep_valid,
   input wire logic rep_ready,
   output logic [settle_pkg::SAMPLE_W-1:0] rep_volt,
   output logic [settle_pkg::SAMPLE_W-1:0] rep_curr,
   output logic [1:0] rep_kind,
   output logic [15:0] status_word,
   output logic sync_mode,
   output logic legacy_mode,
   output logic wait_hold,
   output logic query_valid,
   output logic [settle_pkg::SAMPLE_W-1:0] query_volt,
   output logic [settle_pkg::SAMPLE_W-1:0] query_curr,
   output logic [7:0] query_status
);
   // short names for the reading and sum widths
   localparam int W = settle_pkg::SAMPLE_W;
   localparam int SW = settle_pkg::SUM_W;

   ////////////////////////////////////////////////////////////////////
   // helpers

   // absolute difference, used for both channels
   function automatic logic [W-1:0] abs_diff(input logic [W-1:0] a, input logic [W-1:0] b);
      abs_diff = (a > b) ? (a - b) : (b - a);
   endfunction

   // true when either channel moved by the threshold or more
   function automatic logic moved(input logic [W-1:0] va, input logic [W-1:0] vb,
                                  input logic [W-1:0] ca, input logic [W-1:0] cb);
      moved = (abs_diff(va, vb) >= settle_pkg::CHANGE_LSB) ||
              (abs_diff(ca, cb) >= settle_pkg::CHANGE_LSB);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // sampler and output buffer

   // sampler outputs and buffer handshake
   logic pv;
   logic [W-1:0] pvolt;
   logic [W-1:0] pcurr;
   logic buf_ready;
   logic buf_ovalid;
   logic [2*W+1:0] buf_odata;

   pair_sampler u_samp (
      .core_clk(core_clk),
      .reset(reset),
      .conv_strobe(conv_strobe),
      .volt_in(volt_in),
      .curr_in(curr_in),
      .pair_valid(pv),
      .volt_out(pvolt),
      .curr_out(pcurr)
   );

   // settle states, gray along block, mid, long
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CHASE = 2'h1,
      ST_MID = 2'h3,
      ST_LONG = 2'h2
   } settle_st_t;

   typedef struct packed {
      settle_st_t st;
      logic [3:0] pair_cnt;   // pairs in current block
      logic [SW-1:0] bsum_v;  // block sums
      logic [SW-1:0] bsum_c;
      logic [SW-1:0] lsum_v;  // stable run sums
      logic [SW-1:0] lsum_c;
      logic [7:0] stable_cnt; // stable samples so far
      logic [W-1:0] last_v;   // last reported block values
      logic [W-1:0] last_c;
      logic follow;           // report next block too
      logic force_diff;       // sync restart pending
      logic sync;
      logic legacy;
      logic settling;
      logic push;
      logic [2*W+1:0] pdata;
      logic hold;
      logic qv;
      logic [W-1:0] qvolt;
      logic [W-1:0] qcurr;
      logic [7:0] qstat;
      logic wh; // registered wait answer
      logic [19:0] hold_cyc; // cycles spent holding a wait
   } state_t;
   state_t s_r, s_nxt;

   // the buffer head drives the report pins directly from its flops
   report_buffer u_buf (
      .core_clk(core_clk),
      .reset(reset),
      .in_valid(s_r.push),
      .in_ready(buf_ready),
      .in_data(s_r.pdata),
      .out_valid(buf_ovalid),
      .out_ready(rep_ready),
      .out_data(buf_odata)
   );

   ////////////////////////////////////////////////////////////////////
   // main averaging and settle machine
   always_comb begin
      logic [SW-1:0] nb_v;
      logic [SW-1:0] nb_c;
      logic [W-1:0] avg_v;
      logic [W-1:0] avg_c;
      logic diff;
      nb_v = '0;
      nb_c = '0;
      avg_v = '0;
      avg_c = '0;
      diff = 1'b0;
      s_nxt = s_r;
      // a held push waits for buffer room; pairs arriving meanwhile are dropped
      if (s_r.push && buf_ready) begin
         s_nxt.push = 1'b0;
      end
      // mode selections
      if (measurement_timing_select_wr) begin
         s_nxt.sync = measurement_timing_select_sync;
      end
      if (legacy_command_set_wr) begin
         s_nxt.legacy = legacy_command_set_val;
      end
      // sync restart of the pair logic
      if (s_r.sync && setpoint_change) begin
         s_nxt.pair_cnt = 4'h0; // RL7
         s_nxt.bsum_v = '0;
         s_nxt.bsum_c = '0;
         s_nxt.force_diff = 1'b1; // RL8
         s_nxt.hold = 1'b1; // RL14
      end else if (pv && !(s_r.push && !buf_ready)) begin
         // accumulate one pair
         nb_v = s_r.bsum_v + SW'(pvolt);
         nb_c = s_r.bsum_c + SW'(pcurr);
         s_nxt.bsum_v = nb_v;
         s_nxt.bsum_c = nb_c;
         s_nxt.pair_cnt = s_r.pair_cnt + 4'h1;
         if (s_r.pair_cnt == 4'hF) begin
            // block done: average over 16 pairs
            avg_v = nb_v[W+3:4]; // RL1
            avg_c = nb_c[W+3:4];
            diff = s_r.force_diff ||
                   moved(avg_v, s_r.last_v, avg_c, s_r.last_c); // RL3 RL11
            s_nxt.bsum_v = '0;
            s_nxt.bsum_c = '0;
            s_nxt.force_diff = 1'b0;
            s_nxt.hold = 1'b0; // RL14
            if (diff || s_r.follow) begin
               // changed block and the one after are both reported
               s_nxt.push = 1'b1; // RL2
               s_nxt.pdata = {settle_pkg::REP_BLOCK, avg_v, avg_c};
               s_nxt.last_v = avg_v;
               s_nxt.last_c = avg_c;
               s_nxt.follow = diff;
            end
            if (diff) begin
               // restart the stable run and show settling
               s_nxt.st = ST_CHASE;
               s_nxt.settling = 1'b1; // RL6
               s_nxt.stable_cnt = 8'h00;
               s_nxt.lsum_v = '0;
               s_nxt.lsum_c = '0;
            end else if (s_r.st != ST_IDLE) begin
               // stable block adds 16 samples to the run
               s_nxt.lsum_v = s_r.lsum_v + nb_v; // RL9
               s_nxt.lsum_c = s_r.lsum_c + nb_c;
               s_nxt.stable_cnt = s_r.stable_cnt + 8'h10;
               if (s_r.st == ST_CHASE && s_r.stable_cnt == 8'h30) begin
                  s_nxt.st = ST_MID;
                  s_nxt.push = 1'b1; // RL4
                  s_nxt.pdata = {settle_pkg::REP_MID,
                                 s_nxt.lsum_v[W+5:6], s_nxt.lsum_c[W+5:6]};
               end else if (s_r.st == ST_MID && s_r.stable_cnt == 8'h70) begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.settling = 1'b0; // RL6
                  s_nxt.push = 1'b1; // RL5
                  s_nxt.pdata = {settle_pkg::REP_LONG,
                                 s_nxt.lsum_v[W+6:7], s_nxt.lsum_c[W+6:7]};
               end
            end
         end
      end
      // combined query answers volt, current and status together
      s_nxt.qv = combined_readback_query; // RL15
      if (combined_readback_query) begin
         s_nxt.qvolt = s_r.last_v;
         s_nxt.qcurr = s_r.last_c;
         s_nxt.qstat = {5'h00, s_r.hold, s_r.settling, s_r.sync};
      end
      // hold age restarts with every sync setpoint change and saturates
      if (!s_nxt.hold || (s_r.sync && setpoint_change)) begin
         s_nxt.hold_cyc = 20'h00000;
      end else if (s_r.hold_cyc != 20'hFFFFF) begin
         s_nxt.hold_cyc = s_r.hold_cyc + 20'h00001; // RL12 RL16 RL17
      end
      // wait answer registered so the pin comes straight from a flop
      s_nxt.wh = s_nxt.hold && wait_request; // RL14
      // reset last so it wins over every other update
      if (reset) begin
         s_nxt = '0; // RL19
         s_nxt.sync = 1'b0; // RL10
         s_nxt.legacy = 1'b1; // RL13
         s_nxt.st = ST_IDLE;
      end
   end

   // one register holds the whole state
   always_ff @(posedge core_clk) begin
      s_r <= s_nxt;
   end

   // every pin below is a flop or a fixed bit beside one
   assign rep_valid = buf_ovalid;
   assign rep_kind = buf_odata[2*W+1:2*W];
   assign rep_volt = buf_odata[2*W-1:W];
   assign rep_curr = buf_odata[W-1:0];
   assign status_word = {14'h0000, s_r.settling, 1'b0};
   assign sync_mode = s_r.sync;
   assign legacy_mode = s_r.legacy;
   assign wait_hold = s_r.wh;
   assign query_valid = s_r.qv;
   assign query_volt = s_r.qvolt;
   assign query_curr = s_r.qcurr;
   assign query_status = s_r.qstat;

   ////////////////////////////////////////////////////////////////////
   // checks

   // modes come back to their power-up values one edge after reset
   AST_POWERUP_MODES: assert property (@(posedge core_clk) // RL10 RL13
      reset |=> !sync_mode && legacy_mode)
      else $error("power-up modes wrong");

   // a sync setpoint change empties the block and forces a report
   AST_SYNC_RESTART: assert property (@(posedge core_clk) disable iff (reset) // RL7
      (sync_mode && setpoint_change) |=> (s_r.pair_cnt == 4'h0 && s_r.force_diff))
      else $error("sync restart missing");

   // the first block after a restart is always pushed
   AST_FORCED_REPORT: assert property (@(posedge core_clk) disable iff (reset) // RL8
      (s_r.force_diff && pv && s_r.pair_cnt == 4'hF && !setpoint_change && !s_r.push)
      |=> s_r.push)
      else $error("forced block not reported");

   // settling only starts together with a block report
   AST_SETTLE_BIT: assert property (@(posedge core_clk) disable iff (reset) // RL6
      $rose(status_word[settle_pkg::STATUS_SETTLING_BIT])
      |-> s_r.push && s_r.pdata[2*W+1:2*W] == settle_pkg::REP_BLOCK)
      else $error("settling bit rose without a report");

   // settling only ends with the long average on its way out
   AST_LONG_ENDS: assert property (@(posedge core_clk) disable iff (reset) // RL5
      $fell(s_r.settling) |-> s_r.push && s_r.pdata[2*W+1:2*W] == settle_pkg::REP_LONG)
      else $error("settling ended without long report");

   // entering the mid state always carries the 64 sample report
   AST_MID_REPORT: assert property (@(posedge core_clk) disable iff (reset) // RL4
      (s_r.st == ST_MID && $past(s_r.st) == ST_CHASE)
      |-> s_r.push && s_r.pdata[2*W+1:2*W] == settle_pkg::REP_MID)
      else $error("mid report missing");

   // the query answer appears one edge later with the last block report
   AST_QUERY: assert property (@(posedge core_clk) disable iff (reset) // RL15
      combined_readback_query |=> query_valid && query_volt == $past(s_r.last_v))
      else $error("query answer wrong");

   // a sync setpoint change raises the wait hold
   AST_HOLD: assert property (@(posedge core_clk) disable iff (reset) // RL14
      (sync_mode && setpoint_change) |=> s_r.hold)
      else $error("wait hold not raised");

   // hold drops only at a block end, which is always reported
   AST_HOLD_CLEAR: assert property (@(posedge core_clk) disable iff (reset) // RL8 RL14
      $fell(s_r.hold) |-> s_r.push)
      else $error("hold cleared without a report");

   // a pending wait never outlives the response bound
   AST_HOLD_BOUND: assert property (@(posedge core_clk) disable iff (reset) // RL12 RL16 RL17
      s_r.hold_cyc < 20'(settle_pkg::SYNC_BOUND_CYC))
      else $error("wait hold outlived the response bound");

   // every accepted pair advances the block count by one
   AST_PAIR_COUNT: assert property (@(posedge core_clk) disable iff (reset) // RL1
      (pv && !(s_r.sync && setpoint_change) && !(s_r.push && !buf_ready))
      |=> s_r.pair_cnt == $past(s_r.pair_cnt) + 4'h1)
      else $error("pair count did not advance");

   // the block after a changed one is reported as well
   AST_FOLLOW: assert property (@(posedge core_clk) disable iff (reset) // RL2
      (s_r.follow && pv && s_r.pair_cnt == 4'hF && !(s_r.sync && setpoint_change)
       && !(s_r.push && !buf_ready))
      |=> s_r.push && s_r.pdata[2*W+1:2*W] == settle_pkg::REP_BLOCK)
      else $error("follow block not reported");

   // a stalled report stands unchanged until the consumer takes it
   AST_BUF_HOLD: assert property (@(posedge core_clk) disable iff (reset) // RL2
      (rep_valid && !rep_ready) |=> rep_valid && $stable(rep_volt) && $stable(rep_curr)
      && $stable(rep_kind))
      else $error("stalled report changed");
endmodule

// File: dv/report_sink.sv
/*
 consumer model for the report stream: takes words through valid and ready
 and keeps every accepted report in queues for the bench to read.
 assumes the bench steers stall at the falling edge of core_clk.
*/
module report_sink (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic stall,
   input wire logic rep_valid,
   input wire logic [settle_pkg::SAMPLE_W-1:0] rep_volt,
   input wire logic [settle_pkg::SAMPLE_W-1:0] rep_curr,
   input wire logic [1:0] rep_kind,
   output logic rep_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [settle_pkg::SAMPLE_W-1:0] got_volt[$]; // accepted voltage readings
   logic [settle_pkg::SAMPLE_W-1:0] got_curr[$]; // accepted current readings
   logic [1:0] got_kind[$]; // accepted report kinds
   ////////////////////////////////////////////////////////////////////////////
   // ready moves off the sampling edge; a stall can last any length
   initial rep_ready = 1'b0;
   always @(negedge core_clk) begin
      rep_ready <= !stall && !reset;
   end
   // a word counts only at an edge with valid and ready both high
   always @(posedge core_clk) begin
      if (!reset && rep_valid && rep_ready) begin
         got_volt.push_back(rep_volt);
         got_curr.push_back(rep_curr);
         got_kind.push_back(rep_kind);
      end
   end
endmodule

// File: dv/measurement_settling_averager_tb.sv
/*
 self-checking bench for the measurement settling averager.
 assumes the report_sink model on the report stream and a 10 MHz core clock.
*/
module measurement_settling_averager_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] V = 16'h0400; // settled voltage reading
   localparam logic [15:0] C = 16'h0200; // settled current reading
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic conv_strobe = 1'b0;
   logic [15:0] volt_in = 16'h0000;
   logic [15:0] curr_in = 16'h0000;
   logic mode_wr = 1'b0; // timing select strobe
   logic mode_sync = 1'b0;
   logic set_wr = 1'b0; // command set strobe
   logic set_val = 1'b1;
   logic setpoint_change = 1'b0;
   logic wait_request = 1'b0;
   logic query = 1'b0;
   logic stall = 1'b0;
   logic rep_valid, rep_ready, sync_mode, legacy_mode, wait_hold, query_valid;
   logic [15:0] rep_volt, rep_curr, status_word, query_volt, query_curr;
   logic [1:0] rep_kind;
   logic [7:0] query_status;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   int idx, idx2;
   measurement_settling_averager dut (.core_clk(core_clk), .reset(reset),
      .conv_strobe(conv_strobe), .volt_in(volt_in), .curr_in(curr_in),
      .measurement_timing_select_wr(mode_wr), .measurement_timing_select_sync(mode_sync),
      .legacy_command_set_wr(set_wr), .legacy_command_set_val(set_val),
      .setpoint_change(setpoint_change), .wait_request(wait_request),
      .combined_readback_query(query), .rep_valid(rep_valid), .rep_ready(rep_ready),
      .rep_volt(rep_volt), .rep_curr(rep_curr), .rep_kind(rep_kind),
      .status_word(status_word), .sync_mode(sync_mode), .legacy_mode(legacy_mode),
      .wait_hold(wait_hold), .query_valid(query_valid), .query_volt(query_volt),
      .query_curr(query_curr), .query_status(query_status));
   report_sink sink (.core_clk(core_clk), .reset(reset), .stall(stall),
      .rep_valid(rep_valid), .rep_volt(rep_volt), .rep_curr(rep_curr),
      .rep_kind(rep_kind), .rep_ready(rep_ready));
   ////////////////////////////////////////////////////////////////////////////
   // clock, and a cycle ceiling well above the roughly 1900 cycles needed
   initial begin
      forever #50 core_clk = !core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // one strobe every four cycles carries both channels at once
   task automatic feed(input int n, input logic [15:0] v, input logic [15:0] c);
      repeat (n) begin
         @(negedge core_clk);
         conv_strobe = 1'b1;
         volt_in = v;
         curr_in = c;
         @(negedge core_clk);
         conv_strobe = 1'b0;
         repeat (2) @(negedge core_clk);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge core_clk);
      s = 1'b1;
      @(negedge core_clk);
      s = 1'b0;
   endtask
   // bounded search for the first report of a kind at or after a position
   task automatic find_kind(input int from, input logic [1:0] kind, output int at);
      int t, i;
      at = -1;
      for (t = 0; t < 3000 && at < 0; t++) begin
         for (i = from; i < sink.got_kind.size(); i++)
            if (at < 0 && sink.got_kind[i] === kind) at = i;
         if (at < 0) @(negedge core_clk);
      end
      if (at < 0) check(1'b0, 1'b1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      check(sync_mode, 1'b0);
      check(legacy_mode, 1'b1);
      check(rep_valid, 1'b0);
      check(status_word, settle_pkg::STATUS_RESET);
   endtask
   // first change reported twice while the sink stalls, then 64 and 128 averages
   task automatic test_settle();
      stall = 1'b1;
      feed(32, V, C);
      repeat (8) @(negedge core_clk);
      check(rep_valid, 1'b1);
      check(rep_volt, V);
      check(rep_curr, C);
      check(sink.got_kind.size(), 0);
      check(status_word[settle_pkg::STATUS_SETTLING_BIT], 1'b1);
      stall = 1'b0;
      feed(192, V, C);
      check(sink.got_kind[1], settle_pkg::REP_BLOCK);
      find_kind(0, settle_pkg::REP_MID, idx);
      check(sink.got_volt[idx], V);
      find_kind(idx, settle_pkg::REP_LONG, idx2);
      check(sink.got_curr[idx2], C);
      check(status_word[settle_pkg::STATUS_SETTLING_BIT], 1'b0);
   endtask
   // five LSBs stay quiet, six LSBs on current alone report twice
   task automatic test_threshold();
      int n0;
      n0 = sink.got_kind.size();
      pulse(setpoint_change);
      feed(16, V + 16'h0005, C);
      feed(32, V, C + 16'h0006);
      find_kind(n0, settle_pkg::REP_BLOCK, idx);
      check(sink.got_volt[idx], V);
      check(sink.got_curr[idx], C + 16'h0006);
      find_kind(idx + 1, settle_pkg::REP_BLOCK, idx2);
      check(idx2, idx + 1);
      check(sink.got_curr[idx2], C + 16'h0006);
   endtask
   // bipolar, then sync, then setpoint with wait: a restart forces a report
   task automatic test_sync();
      int n0;
      set_val = 1'b0;
      pulse(set_wr);
      mode_sync = 1'b1;
      pulse(mode_wr);
      check(legacy_mode, 1'b0);
      check(sync_mode, 1'b1);
      feed(7, V + 16'h0100, C + 16'h0006);
      n0 = sink.got_kind.size();
      wait_request = 1'b1;
      pulse(setpoint_change);
      @(negedge core_clk);
      check(wait_hold, 1'b1);
      feed(16, V, C + 16'h0006);
      find_kind(n0, settle_pkg::REP_BLOCK, idx);
      check(sink.got_volt[idx], V);
      check(sink.got_curr[idx], C + 16'h0006);
      repeat (4) @(negedge core_clk);
      check(wait_hold, 1'b0);
      wait_request = 1'b0;
      feed(160, V, C + 16'h0006);
      find_kind(idx, settle_pkg::REP_LONG, idx2);
      check(sink.got_volt[idx2], V);
   endtask
   // the combined query answers with both readings and the hold, settling and sync flags
   task automatic test_query();
      int t;
      pulse(query);
      for (t = 0; t < 50 && query_valid !== 1'b1; t++) @(negedge core_clk);
      check(query_valid, 1'b1);
      check(query_volt, V);
      check(query_curr, C + 16'h0006);
      check(query_status[2:0], 3'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(negedge core_clk);
      reset = 1'b0;
      test_reset();
      test_settle();
      test_threshold();
      test_sync();
      test_query();
      close_out();
   end
endmodule
